// >>> timer_ctl_defs.svh
`ifndef TIMER_CTL_DEFS_SVH
`define TIMER_CTL_DEFS_SVH

`define TCTL_ADDR 8'h88
`define TIMER_MODE_SELECT_ADDR 8'h89
`define TL0_ADDR 8'h8A
`define TH0_ADDR 8'h8C
`define TCTL_RESET 8'h00
`define TIMER_MODE_SELECT_RESET 8'h00
`define CNT_RESET 8'h00
`define TCTL_TF1 7
`define TCTL_TR1 6
`define TCTL_TF0 5
`define TCTL_TR0 4
`define TCTL_IE1 3
`define TCTL_IT1 2
`define TCTL_IE0 1
`define TCTL_IT0 0
`define TIMER_MODE_SELECT_GATE0 3
`define TIMER_MODE_SELECT_CT0 2
`define TIMER_MODE_SELECT_M1 1
`define TIMER_MODE_SELECT_M0 0
`define MODE13_MAX 13'h1FFF

`endif

// >>> timer_ctl_pkg.sv
package timer_ctl_pkg;
   typedef enum logic [1:0] {
      MODE_13BIT,
      MODE_16BIT,
      MODE_8BIT_RELOAD,
      MODE_SPLIT
   } t0_mode_e;
endpackage

// >>> timer_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface timer_edge_if;
   logic pin;
   logic fall;
   modport det (input pin, output fall);
   modport user (output pin, input fall);
endinterface
`default_nettype wire

// >>> timer_fall_detect.sv
`timescale 1ns/1ps
`default_nettype none
module timer_fall_detect (
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Pin and edge.
   timer_edge_if.det e
);
   logic last;

   // Remembers the level sampled in the previous cycle.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         last <= 1'b1;
      end else begin
         last <= e.pin;
      end
   end

   // High in the cycle the pin is low after a high sample.
   assign e.fall = last & ~e.pin;
endmodule
`default_nettype wire

// >>> timer_ctl.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctl_defs.svh"

module timer_ctl (
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Register port.
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Single-bit write port.
   input wire logic [2:0] bit_sel,
   input wire logic bit_val,
   input wire logic bit_wr,
   // Pins.
   input wire logic ext_irq_zero_pin,
   input wire logic ext_irq_one_pin,
   input wire logic timer_zero_count_pin,
   // Timer one overflow and acknowledges.
   input wire logic timer_one_ovf,
   input wire logic ack_t0,
   input wire logic ack_t1,
   input wire logic ack_x0,
   input wire logic ack_x1,
   // Status.
   output logic timer_one_run,
   output logic timer_zero_overflow_flag,
   output logic timer_one_overflow_flag,
   output logic ext_irq_zero_flag,
   output logic ext_irq_one_flag
);
   import timer_ctl_pkg::*;

   logic [7:0] timer_control;
   logic [7:0] timer_mode_select;
   logic [7:0] timer_zero_low_byte;
   logic [7:0] timer_zero_high_byte;
   logic cw;
   logic [7:0] next_ctl;
   logic cnt_fall;
   logic x0_fall;
   logic x1_fall;
   logic lo_tick;
   logic hi_tick;
   logic lo_ovf;
   logic hi_ovf;
   logic ovf0;
   logic [12:0] c13;
   t0_mode_e mode;

   timer_edge_if cnt_if ();
   timer_edge_if x0_if ();
   timer_edge_if x1_if ();
   assign cnt_if.pin = timer_zero_count_pin;
   assign x0_if.pin = ext_irq_zero_pin;
   assign x1_if.pin = ext_irq_one_pin;
   assign cnt_fall = cnt_if.fall;
   assign x0_fall = x0_if.fall;
   assign x1_fall = x1_if.fall;

   timer_fall_detect u_cnt (.clk(clk), .sys_rst(sys_rst), .e(cnt_if));
   timer_fall_detect u_x0 (.clk(clk), .sys_rst(sys_rst), .e(x0_if));
   timer_fall_detect u_x1 (.clk(clk), .sys_rst(sys_rst), .e(x1_if));

   assign mode = t0_mode_e'(timer_mode_select[`TIMER_MODE_SELECT_M1:`TIMER_MODE_SELECT_M0]);

   // Low-byte counter enable: run bit, gate and clock source.
   always_comb begin
      lo_tick = timer_control[`TCTL_TR0]
         & (~timer_mode_select[`TIMER_MODE_SELECT_GATE0] | ext_irq_zero_pin)
         & (~timer_mode_select[`TIMER_MODE_SELECT_CT0] | cnt_fall);
   end

   // High byte in split mode counts clocks on the timer one run bit.
   assign hi_tick = (mode == MODE_SPLIT) & timer_control[`TCTL_TR1];
   assign c13 = {timer_zero_high_byte, timer_zero_low_byte[4:0]};

   always_comb begin
      case (mode)
         MODE_13BIT: lo_ovf = lo_tick & (c13 == `MODE13_MAX);
         MODE_16BIT: lo_ovf = lo_tick & (&{timer_zero_high_byte, timer_zero_low_byte});
         MODE_8BIT_RELOAD: lo_ovf = lo_tick & (&timer_zero_low_byte);
         MODE_SPLIT: lo_ovf = lo_tick & (&timer_zero_low_byte);
         default: lo_ovf = 1'b0;
      endcase
   end
   assign hi_ovf = hi_tick & (&timer_zero_high_byte);
   assign ovf0 = lo_ovf;

   // Timer zero count bytes with software writes.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timer_zero_low_byte <= `CNT_RESET;
         timer_zero_high_byte <= `CNT_RESET;
      end else begin
         case (mode)
            MODE_13BIT: begin
               if (lo_tick) begin
                  timer_zero_low_byte <= {3'b000, c13[4:0] + 5'h01} | 
                     (timer_zero_low_byte & 8'hE0);
                  if (&c13[4:0]) begin
                     timer_zero_high_byte <= timer_zero_high_byte + 8'h01;
                  end
               end
            end
            MODE_16BIT: begin
               if (lo_tick) begin
                  timer_zero_low_byte <= timer_zero_low_byte + 8'h01;
                  if (&timer_zero_low_byte) begin
                     timer_zero_high_byte <= timer_zero_high_byte + 8'h01;
                  end
               end
            end
            MODE_8BIT_RELOAD: begin
               if (lo_ovf) begin
                  timer_zero_low_byte <= timer_zero_high_byte;
               end else if (lo_tick) begin
                  timer_zero_low_byte <= timer_zero_low_byte + 8'h01;
               end
            end
            MODE_SPLIT: begin
               if (lo_tick) begin
                  timer_zero_low_byte <= timer_zero_low_byte + 8'h01;
               end
               if (hi_tick) begin
                  timer_zero_high_byte <= timer_zero_high_byte + 8'h01;
               end
            end
            default: begin
               timer_zero_low_byte <= timer_zero_low_byte;
            end
         endcase
         if (wr && addr == `TL0_ADDR) begin
            timer_zero_low_byte <= wdata;
         end
         if (wr && addr == `TH0_ADDR) begin
            timer_zero_high_byte <= wdata;
         end
      end
   end

   // Mode select register.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timer_mode_select <= `TIMER_MODE_SELECT_RESET;
      end else if (wr && addr == `TIMER_MODE_SELECT_ADDR) begin
         timer_mode_select <= wdata;
      end
   end

   // Software view of the control register: byte or single bit.
   assign cw = (wr && addr == `TCTL_ADDR) || bit_wr;
   always_comb begin
      next_ctl = timer_control;
      if (wr && addr == `TCTL_ADDR) begin
         next_ctl = wdata;
      end else if (bit_wr) begin
         next_ctl[bit_sel] = bit_val;
      end
   end

   // Control register: hardware sets win over clears.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timer_control <= `TCTL_RESET;
      end else begin
         timer_control[`TCTL_TR1] <= cw ? next_ctl[`TCTL_TR1] : timer_control[`TCTL_TR1];
         timer_control[`TCTL_TR0] <= cw ? next_ctl[`TCTL_TR0] : timer_control[`TCTL_TR0];
         timer_control[`TCTL_IT1] <= cw ? next_ctl[`TCTL_IT1] : timer_control[`TCTL_IT1];
         timer_control[`TCTL_IT0] <= cw ? next_ctl[`TCTL_IT0] : timer_control[`TCTL_IT0];
         // In split mode the high byte takes over the timer one flag.
         if ((mode == MODE_SPLIT) ? hi_ovf : timer_one_ovf) begin
            timer_control[`TCTL_TF1] <= 1'b1;
         end else if (ack_t1) begin
            timer_control[`TCTL_TF1] <= 1'b0;
         end else if (cw) begin
            timer_control[`TCTL_TF1] <= next_ctl[`TCTL_TF1];
         end
         if (ovf0) begin
            timer_control[`TCTL_TF0] <= 1'b1;
         end else if (ack_t0) begin
            timer_control[`TCTL_TF0] <= 1'b0;
         end else if (cw) begin
            timer_control[`TCTL_TF0] <= next_ctl[`TCTL_TF0];
         end
         if (!timer_control[`TCTL_IT1]) begin
            timer_control[`TCTL_IE1] <= ~ext_irq_one_pin;
         end else if (x1_fall) begin
            timer_control[`TCTL_IE1] <= 1'b1;
         end else if (ack_x1) begin
            timer_control[`TCTL_IE1] <= 1'b0;
         end else if (cw) begin
            timer_control[`TCTL_IE1] <= next_ctl[`TCTL_IE1];
         end
         if (!timer_control[`TCTL_IT0]) begin
            timer_control[`TCTL_IE0] <= ~ext_irq_zero_pin;
         end else if (x0_fall) begin
            timer_control[`TCTL_IE0] <= 1'b1;
         end else if (ack_x0) begin
            timer_control[`TCTL_IE0] <= 1'b0;
         end else if (cw) begin
            timer_control[`TCTL_IE0] <= next_ctl[`TCTL_IE0];
         end
      end
   end

   // Read data registered one cycle after the strobe.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            `TCTL_ADDR: rdata <= timer_control;
            `TIMER_MODE_SELECT_ADDR: rdata <= timer_mode_select;
            `TL0_ADDR: rdata <= timer_zero_low_byte;
            `TH0_ADDR: rdata <= timer_zero_high_byte;
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   assign timer_one_run = timer_control[`TCTL_TR1] & (mode != MODE_SPLIT);
   assign timer_zero_overflow_flag = timer_control[`TCTL_TF0];
   assign timer_one_overflow_flag = timer_control[`TCTL_TF1];
   assign ext_irq_zero_flag = timer_control[`TCTL_IE0];
   assign ext_irq_one_flag = timer_control[`TCTL_IE1];

   a_run_stop_hold: assert property (@(posedge clk) disable iff (sys_rst)
      !timer_control[`TCTL_TR0] && !wr && mode != MODE_SPLIT
      |=> $stable(timer_zero_low_byte))
      else $error("Timer zero low byte moved while stopped.");
   a_gate_block: assert property (@(posedge clk) disable iff (sys_rst)
      timer_mode_select[`TIMER_MODE_SELECT_GATE0] && !ext_irq_zero_pin |-> !lo_tick)
      else $error("Gated timer counted with pin low.");
   a_ovf0_sets: assert property (@(posedge clk) disable iff (sys_rst)
      ovf0 |=> timer_control[`TCTL_TF0])
      else $error("Overflow did not set timer zero flag.");
   a_ack0_clears: assert property (@(posedge clk) disable iff (sys_rst)
      ack_t0 && !ovf0 |=> !timer_control[`TCTL_TF0])
      else $error("Acknowledge did not clear timer zero flag.");
   a_lvl_x0: assert property (@(posedge clk) disable iff (sys_rst)
      !timer_control[`TCTL_IT0] && !cw |=> timer_control[`TCTL_IE0] == !$past(ext_irq_zero_pin))
      else $error("Level flag zero does not follow pin.");
   a_edge_x1: assert property (@(posedge clk) disable iff (sys_rst)
      timer_control[`TCTL_IT1] && x1_fall |=> timer_control[`TCTL_IE1])
      else $error("Falling edge did not set flag one.");
   a_reload_low: assert property (@(posedge clk) disable iff (sys_rst)
      mode == MODE_8BIT_RELOAD && lo_ovf && !wr
      |=> timer_zero_low_byte == $past(timer_zero_high_byte) && $stable(timer_zero_high_byte))
      else $error("Reload did not copy high byte.");
   a_wrap13: assert property (@(posedge clk) disable iff (sys_rst)
      mode == MODE_13BIT && lo_tick && c13 == `MODE13_MAX && !wr
      |=> timer_control[`TCTL_TF0] && timer_zero_high_byte == 8'h00)
      else $error("13-bit wrap wrong.");
   a_ovf1_sets: assert property (@(posedge clk) disable iff (sys_rst)
      mode != MODE_SPLIT && timer_one_ovf
      |=> timer_control[`TCTL_TF1])
      else $error("Timer one overflow did not set its flag.");
   a_split_tf1: assert property (@(posedge clk) disable iff (sys_rst)
      mode == MODE_SPLIT && hi_ovf
      |=> timer_control[`TCTL_TF1])
      else $error("Split high byte overflow did not set flag one.");
   a_ack1_clears: assert property (@(posedge clk) disable iff (sys_rst)
      ack_t1 && !((mode == MODE_SPLIT) ? hi_ovf : timer_one_ovf)
      |=> !timer_control[`TCTL_TF1])
      else $error("Acknowledge did not clear timer one flag.");
   a_split_high: assert property (@(posedge clk) disable iff (sys_rst)
      mode == MODE_SPLIT && timer_control[`TCTL_TR1] && !(wr && addr == `TH0_ADDR)
      |=> timer_zero_high_byte == $past(timer_zero_high_byte) + 8'h01)
      else $error("Split high byte did not count a clock.");
   a_edge_x0: assert property (@(posedge clk) disable iff (sys_rst)
      timer_control[`TCTL_IT0] && x0_fall
      |=> timer_control[`TCTL_IE0])
      else $error("Falling edge did not set flag zero.");
   a_lvl_x1: assert property (@(posedge clk) disable iff (sys_rst)
      !timer_control[`TCTL_IT1] && !cw
      |=> timer_control[`TCTL_IE1] == !$past(ext_irq_one_pin))
      else $error("Level flag one does not follow pin.");
   a_ack_x0: assert property (@(posedge clk) disable iff (sys_rst)
      timer_control[`TCTL_IT0] && ack_x0 && !x0_fall
      |=> !timer_control[`TCTL_IE0])
      else $error("Acknowledge did not clear flag zero.");
   a_ack_x1: assert property (@(posedge clk) disable iff (sys_rst)
      timer_control[`TCTL_IT1] && ack_x1 && !x1_fall
      |=> !timer_control[`TCTL_IE1])
      else $error("Acknowledge did not clear flag one.");
   a_ctl_reset: assert property (@(posedge clk)
      sys_rst
      |=> timer_control == `TCTL_RESET)
      else $error("Control register not cleared by reset.");
   a_bit_write: assert property (@(posedge clk) disable iff (sys_rst)
      bit_wr && !(wr && addr == `TCTL_ADDR) && bit_sel == 3'(`TCTL_TR0)
      |=> timer_control[`TCTL_TR0] == $past(bit_val))
      else $error("Single-bit write did not reach the run bit.");
   a_byte_write: assert property (@(posedge clk) disable iff (sys_rst)
      wr && addr == `TCTL_ADDR
      |=> timer_control[`TCTL_TR0] == $past(wdata[`TCTL_TR0]))
      else $error("Byte write did not reach the run bit.");
   a_timer_tick: assert property (@(posedge clk) disable iff (sys_rst)
      timer_control[`TCTL_TR0] && !timer_mode_select[`TIMER_MODE_SELECT_GATE0]
      && !timer_mode_select[`TIMER_MODE_SELECT_CT0] |-> lo_tick)
      else $error("Timer zero missed a clock.");
   a_count_edge: assert property (@(posedge clk) disable iff (sys_rst)
      timer_mode_select[`TIMER_MODE_SELECT_CT0] && !cnt_fall
      |-> !lo_tick)
      else $error("Counter zero counted without a falling edge.");
   a_count16: assert property (@(posedge clk) disable iff (sys_rst)
      mode == MODE_16BIT && lo_tick && !wr
      |=> {timer_zero_high_byte, timer_zero_low_byte} == $past({timer_zero_high_byte, timer_zero_low_byte}) + 16'h0001)
      else $error("16-bit count did not advance by one.");
   a_tr0_stop: assert property (@(posedge clk) disable iff (sys_rst)
      !timer_control[`TCTL_TR0]
      |-> !lo_tick)
      else $error("Timer zero counted while stopped.");
endmodule
`default_nettype wire

// >>> pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_model (
   // Clock.
   input wire logic clk,
   // Pins, idle high as with a pull-up.
   output logic x0,
   output logic x1,
   output logic cnt
);
   initial begin
      x0 = 1'b1;
      x1 = 1'b1;
      cnt = 1'b1;
   end
   // Sets one interrupt pin just after an edge.
   task automatic level(input logic which, input logic v);
      @(posedge clk);
      if (which) begin
         x1 <= v;
      end else begin
         x0 <= v;
      end
   endtask
   // Pulses stay low two clocks so that every fall is sampled.
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk);
         cnt <= 1'b0;
         repeat (2) @(posedge clk);
         cnt <= 1'b1;
         @(posedge clk);
      end
      repeat (3) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctl_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
   logic clk, sys_rst, wr, rd, bit_val, bit_wr;
   logic [7:0] addr, wdata, rdata;
   logic [2:0] bit_sel;
   logic [4:0] ev;
   logic x0, x1, cnt, t1_run, tf0, tf1, ie0, ie1;
   int n_fail = 0;
   int checked = 0;
   pin_model PIN (.clk(clk), .x0(x0), .x1(x1), .cnt(cnt));
   timer_ctl DUT (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .bit_sel(bit_sel), .bit_val(bit_val), .bit_wr(bit_wr),
      .ext_irq_zero_pin(x0), .ext_irq_one_pin(x1), .timer_zero_count_pin(cnt),
      .timer_one_ovf(ev[4]), .ack_t0(ev[0]), .ack_t1(ev[1]), .ack_x0(ev[2]),
      .ack_x1(ev[3]), .timer_one_run(t1_run), .timer_zero_overflow_flag(tf0),
      .timer_one_overflow_flag(tf1), .ext_irq_zero_flag(ie0), .ext_irq_one_flag(ie1));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic wreg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK("rdata", e, rdata)
   endtask
   task automatic bwr(input int s, input logic v);
      @(posedge clk);
      bit_sel <= 3'(s);
      bit_val <= v;
      bit_wr <= 1'b1;
      @(posedge clk);
      bit_wr <= 1'b0;
   endtask
   task automatic pev(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev <= 5'h0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic summarize;
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Runs counter mode through one pulse train.
   task automatic run_cnt(input int n);
      bwr(`TCTL_TR0, 1'b1);
      PIN.pulse(n);
      bwr(`TCTL_TR0, 1'b0);
   endtask
   initial begin
      sys_rst = 1'b1;
      {wr, rd, bit_val, bit_wr, addr, wdata, bit_sel, ev} = '0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rchk(`TCTL_ADDR, 8'h00);
      rchk(8'h90, 8'h00);
      wreg(`TIMER_MODE_SELECT_ADDR, 8'h01);
      wreg(`TCTL_ADDR, 8'h10);
      repeat (10) @(posedge clk);
      bwr(`TCTL_TR0, 1'b0);
      rchk(`TL0_ADDR, 8'h0C);
      wreg(`TIMER_MODE_SELECT_ADDR, 8'h05);
      wreg(`TL0_ADDR, 8'hFE);
      wreg(`TH0_ADDR, 8'hFF);
      run_cnt(2);
      rchk(`TL0_ADDR, 8'h00);
      rchk(`TH0_ADDR, 8'h00);
      rchk(`TCTL_ADDR, 8'h20);
      pev(0);
      settle(1);
      `CHK("tf0", 1'b0, tf0)
      wreg(`TIMER_MODE_SELECT_ADDR, 8'h04);
      wreg(`TL0_ADDR, 8'hFF);
      wreg(`TH0_ADDR, 8'hFF);
      run_cnt(1);
      rchk(`TL0_ADDR, 8'hE0);
      rchk(`TH0_ADDR, 8'h00);
      `CHK("tf0", 1'b1, tf0)
      bwr(`TCTL_TF0, 1'b0);
      settle(1);
      `CHK("tf0", 1'b0, tf0)
      wreg(`TIMER_MODE_SELECT_ADDR, 8'h06);
      wreg(`TH0_ADDR, 8'h80);
      wreg(`TL0_ADDR, 8'hFF);
      run_cnt(2);
      rchk(`TL0_ADDR, 8'h81);
      rchk(`TH0_ADDR, 8'h80);
      wreg(`TIMER_MODE_SELECT_ADDR, 8'h07);
      wreg(`TL0_ADDR, 8'h00);
      wreg(`TH0_ADDR, 8'hFE);
      bwr(`TCTL_TR1, 1'b1);
      settle(1);
      `CHK("t1_run", 1'b0, t1_run)
      run_cnt(3);
      `CHK("tf1", 1'b1, tf1)
      bwr(`TCTL_TR1, 1'b0);
      rchk(`TL0_ADDR, 8'h03);
      wreg(`TIMER_MODE_SELECT_ADDR, 8'h0D);
      wreg(`TL0_ADDR, 8'h00);
      PIN.level(1'b0, 1'b0);
      bwr(`TCTL_TR0, 1'b1);
      PIN.pulse(2);
      rchk(`TL0_ADDR, 8'h00);
      PIN.level(1'b0, 1'b1);
      run_cnt(2);
      rchk(`TL0_ADDR, 8'h02);
      PIN.pulse(2);
      rchk(`TL0_ADDR, 8'h02);
      wreg(`TIMER_MODE_SELECT_ADDR, 8'h00);
      pev(4);
      settle(1);
      `CHK("tf1", 1'b1, tf1)
      pev(1);
      settle(1);
      `CHK("tf1", 1'b0, tf1)
      bwr(`TCTL_TF1, 1'b1);
      settle(1);
      `CHK("tf1", 1'b1, tf1)
      wreg(`TCTL_ADDR, 8'h40);
      settle(1);
      `CHK("t1_run", 1'b1, t1_run)
      rchk(`TCTL_ADDR, 8'h40);
      wreg(`TCTL_ADDR, 8'h00);
      for (int i = 0; i < 2; i++) begin
         PIN.level(i[0], 1'b0);
         settle(2);
         `CHK("ie", 1'b1, (i ? ie1 : ie0))
         PIN.level(i[0], 1'b1);
         bwr(1 + 2 * i, 1'b1);
         settle(2);
         `CHK("ie", 1'b0, (i ? ie1 : ie0))
         bwr(2 * i, 1'b1);
         PIN.level(i[0], 1'b0);
         PIN.level(i[0], 1'b1);
         settle(3);
         `CHK("ie", 1'b1, (i ? ie1 : ie0))
         pev(2 + i);
         settle(1);
         `CHK("ie", 1'b0, (i ? ie1 : ie0))
         bwr(2 * i, 1'b0);
      end
      summarize;
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      summarize;
   end
endmodule
`default_nettype wire
